/* logic/pmf_pkg.sv */
// Shared constants and types of the pixel mode formatter.
// Assumes one 50 MHz system clock and a plain register port.
package pmf_pkg;
	localparam int PIX_BUS_W = 64;
	localparam int REG_ADDR_W = 6;

	// Register offsets
	localparam logic [5:0] OFS_MUX_CTRL = 6'h00;
	localparam logic [5:0] OFS_MODE_CTRL = 6'h04;
	localparam logic [5:0] OFS_PAGE = 6'h08;
	localparam logic [5:0] OFS_READ_MASK = 6'h0C;
	localparam logic [5:0] OFS_MISC_CTRL = 6'h10;
	localparam logic [5:0] OFS_KEY_CTRL = 6'h14;
	localparam logic [5:0] OFS_CLOCK_SEL = 6'h18;
	localparam logic [5:0] OFS_PAL_INDEX = 6'h1C;
	localparam logic [5:0] OFS_PAL_DATA = 6'h20;
	localparam logic [5:0] OFS_STATUS = 6'h24;

	// Field positions
	localparam int VGA_PORT_SELECT_BIT = 7;
	localparam int VGA_LATCH_SOURCE_BIT = 6;
	localparam int BUS_WIDTH_LSB = 4;
	localparam int SUBMODE_LSB = 0;
	localparam int COLOR_MODE_LSB = 0;
	localparam int DAC_8BIT_BIT = 3;
	localparam int PORT_SELECT_ENABLE_BIT = 4;
	localparam int PORT_SELECT_PATH_BIT = 5;
	localparam int COLOR_KEY_CONTROL_BIT0 = 0;
	localparam int COLOR_KEY_CONTROL_BIT4 = 4;
	localparam int CLOCK_SOURCE_SELECT_LSB = 0;
	localparam int RCLK_SOURCE_SELECT_BIT = 4;
	localparam logic [3:0] CLOCK_SOURCE_VGA = 4'h7;

	// Reset values
	localparam logic [7:0] RST_MUX_CTRL = 8'h80;
	localparam logic [7:0] RST_MODE_CTRL = 8'h00;
	localparam logic [7:0] RST_PAGE = 8'h00;
	localparam logic [7:0] RST_READ_MASK = 8'hFF;
	localparam logic [7:0] RST_MISC_CTRL = 8'h08;
	localparam logic [7:0] RST_KEY_CTRL = 8'h00;
	localparam logic [7:0] RST_CLOCK_SEL = 8'h00;
	localparam logic [7:0] RST_PAL_INDEX = 8'h00;

	// Submode codes
	localparam logic [3:0] SM_PS_NIBBLE = 4'h1;
	localparam logic [3:0] SM_PS_SWAP = 4'h2;
	localparam logic [3:0] SM_PS_BYTE = 4'h3;
	localparam logic [3:0] SM_DC_ORGB = 4'h3;
	localparam logic [3:0] SM_DC_BGRO = 4'h4;
	localparam logic [3:0] SM_DC_565 = 4'h5;
	localparam logic [3:0] SM_DC_1555 = 4'h6;
	localparam logic [3:0] SM_DC_664 = 4'h7;
	localparam logic [3:0] SM_DC_4444 = 4'h8;

	typedef enum logic [1:0] {PMF_PSEUDO, PMF_DIRECT, PMF_TRUE} pmf_color_mode_t;

	typedef struct packed {
		logic [5:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} pmf_reg_req_t;

	typedef struct packed {
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
	} pmf_rgb_t;

	typedef struct packed {
		logic has_ovl;
		logic [7:0] ovl;
		pmf_rgb_t rgb;
	} pmf_pixel_t;

	typedef struct packed {
		logic [63:0] pix;
		logic pix_blank_n;
		logic [7:0] vga;
		logic vga_blank_n;
	} pmf_pin_t;
endpackage

/* logic/pmf_formatter.sv */
// Pixel mode formatter: pixel bus and VGA port to palette address and DAC data.
// Assumes pins asynchronous to clk_sys, latch clocks much slower than clk_sys.
`timescale 1ns/10ps
module pmf_formatter #(
	parameter int PAL_DEPTH = 256
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire pmf_pkg::pmf_reg_req_t reg_req,
	output logic [31:0] reg_rdata,
	input wire logic latch_clock_in,
	input wire logic [63:0] pixel_bus_in,
	input wire logic pixel_blank_n_in,
	input wire logic vga_clock_input,
	input wire logic [7:0] vga_pixel_inputs,
	input wire logic vga_blank_n_in,
	output pmf_pkg::pmf_rgb_t dac_data,
	output logic dac_blank_n,
	output logic [7:0] pal_addr_out,
	output logic pix_valid
);
	import pmf_pkg::*;

	logic [7:0] mux_ctrl_reg;
	logic [7:0] mode_ctrl_reg;
	logic [7:0] page_reg;
	logic [7:0] read_mask_reg;
	logic [7:0] misc_ctrl_reg;
	logic [7:0] key_ctrl_reg;
	logic [7:0] clock_sel_reg;
	logic [7:0] pal_index_reg;
	logic [7:0] pal_red [PAL_DEPTH];
	logic [7:0] pal_green [PAL_DEPTH];
	logic [7:0] pal_blue [PAL_DEPTH];
	pmf_pin_t pin_s1_reg;
	pmf_pin_t pin_s2_reg;
	pmf_pin_t pin_s3_reg;
	logic [2:0] lclk_sync_reg;
	logic [2:0] vclk_sync_reg;
	logic [63:0] shift_reg;
	logic [4:0] remain_reg;
	logic blank_n_reg;
	pmf_rgb_t pal_q_reg;
	pmf_pixel_t dec_b_reg;
	logic pseudo_b_reg;
	logic true_b_reg;
	logic use_pal_b_reg;
	logic valid_b_reg;
	logic blank_b_reg;
	logic dac8_b_reg;

	logic vga_active;
	logic vga_latch_src;
	pmf_color_mode_t color_mode;
	logic [3:0] submode;
	logic [1:0] bus_code;
	logic pseudo_like;
	logic lclk_rise;
	logic vclk_rise;
	logic latch_evt;
	logic pix_present;
	logic use_palette;
	logic [2:0] lg_bpp;
	logic [2:0] lg_bus;
	logic [5:0] bpp;
	logic [4:0] pix_per_latch;
	logic [31:0] cur;
	pmf_pixel_t dec;
	logic [7:0] ovl_addr;
	logic [7:0] rd_addr_r;
	logic [7:0] rd_addr_g;
	logic [7:0] rd_addr_b;

	function automatic logic [63:0] bus_mask(input logic [1:0] code);
		case (code)
			2'h0: bus_mask = 64'h0000_0000_0000_00FF;
			2'h1: bus_mask = 64'h0000_0000_0000_FFFF;
			2'h2: bus_mask = 64'h0000_0000_FFFF_FFFF;
			default: bus_mask = 64'hFFFF_FFFF_FFFF_FFFF;
		endcase
	endfunction

	function automatic logic [63:0] swap_nibbles(input logic [63:0] d);
		for (int i = 0; i < 8; i++) begin
			swap_nibbles[8*i +: 8] = {d[8*i +: 4], d[8*i+4 +: 4]};
		end
	endfunction

	function automatic logic [7:0] dac_width(input logic [7:0] v, input logic eight);
		dac_width = eight ? v : {v[5:0], 2'h0};
	endfunction

	// Register writes
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			mux_ctrl_reg <= RST_MUX_CTRL;
			mode_ctrl_reg <= RST_MODE_CTRL;
			page_reg <= RST_PAGE;
			read_mask_reg <= RST_READ_MASK;
			misc_ctrl_reg <= RST_MISC_CTRL;
			key_ctrl_reg <= RST_KEY_CTRL;
			clock_sel_reg <= RST_CLOCK_SEL;
			pal_index_reg <= RST_PAL_INDEX;
		end else if (reg_req.wr) begin
			case (reg_req.addr)
				OFS_MUX_CTRL: mux_ctrl_reg <= reg_req.wdata[7:0];
				OFS_MODE_CTRL: mode_ctrl_reg <= reg_req.wdata[7:0];
				OFS_PAGE: page_reg <= reg_req.wdata[7:0];
				OFS_READ_MASK: read_mask_reg <= reg_req.wdata[7:0];
				OFS_MISC_CTRL: misc_ctrl_reg <= reg_req.wdata[7:0];
				OFS_KEY_CTRL: key_ctrl_reg <= reg_req.wdata[7:0];
				OFS_CLOCK_SEL: clock_sel_reg <= reg_req.wdata[7:0];
				OFS_PAL_INDEX: pal_index_reg <= reg_req.wdata[7:0];
				OFS_PAL_DATA: pal_index_reg <= pal_index_reg + 8'h01;
				default: begin
				end
			endcase
		end
	end

	// Register reads, data in the following cycle only
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_req.rd) begin
			case (reg_req.addr)
				OFS_MUX_CTRL: reg_rdata <= {24'h00_0000, mux_ctrl_reg};
				OFS_MODE_CTRL: reg_rdata <= {24'h00_0000, mode_ctrl_reg};
				OFS_PAGE: reg_rdata <= {24'h00_0000, page_reg};
				OFS_READ_MASK: reg_rdata <= {24'h00_0000, read_mask_reg};
				OFS_MISC_CTRL: reg_rdata <= {24'h00_0000, misc_ctrl_reg};
				OFS_KEY_CTRL: reg_rdata <= {24'h00_0000, key_ctrl_reg};
				OFS_CLOCK_SEL: reg_rdata <= {24'h00_0000, clock_sel_reg};
				OFS_PAL_INDEX: reg_rdata <= {24'h00_0000, pal_index_reg};
				OFS_STATUS: reg_rdata <= {21'h0_0000, remain_reg, vga_latch_src,
					vga_active, use_palette,
					clock_sel_reg[CLOCK_SOURCE_SELECT_LSB +: 4] == CLOCK_SOURCE_VGA,
					blank_n_reg, pix_present};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// Pin synchronisers; data gets one stage more than the clock edge detector
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
			pin_s3_reg <= '0;
			lclk_sync_reg <= 3'h0;
			vclk_sync_reg <= 3'h0;
		end else begin
			pin_s1_reg <= {pixel_bus_in, pixel_blank_n_in, vga_pixel_inputs, vga_blank_n_in};
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			lclk_sync_reg <= {lclk_sync_reg[1:0], latch_clock_in};
			vclk_sync_reg <= {vclk_sync_reg[1:0], vga_clock_input};
		end
	end

	assign vga_active = mux_ctrl_reg[VGA_PORT_SELECT_BIT];
	assign vga_latch_src = mux_ctrl_reg[VGA_LATCH_SOURCE_BIT];
	assign color_mode = pmf_color_mode_t'(mode_ctrl_reg[COLOR_MODE_LSB +: 2]);
	assign submode = mux_ctrl_reg[SUBMODE_LSB +: 4];
	assign bus_code = mux_ctrl_reg[BUS_WIDTH_LSB +: 2];
	assign pseudo_like = vga_active || (color_mode == PMF_PSEUDO);
	assign lclk_rise = lclk_sync_reg[1] & ~lclk_sync_reg[2];
	assign vclk_rise = vclk_sync_reg[1] & ~vclk_sync_reg[2];
	// VGA data follows the VGA clock unless the latch source bit picks the pixel clock
	assign latch_evt = (vga_active && !vga_latch_src) ? vclk_rise : lclk_rise;
	assign pix_present = remain_reg != 5'h00;
	assign use_palette = !misc_ctrl_reg[PORT_SELECT_PATH_BIT] ||
		(key_ctrl_reg[COLOR_KEY_CONTROL_BIT4] && key_ctrl_reg[COLOR_KEY_CONTROL_BIT0]);
	assign lg_bus = 3'h3 + {1'b0, bus_code};

	// Bits per pixel of the current mode
	always_comb begin
		lg_bpp = 3'h5;
		if (vga_active) begin
			lg_bpp = 3'h3;
		end else if (color_mode == PMF_PSEUDO) begin
			lg_bpp = (submode == SM_PS_BYTE) ? 3'h3 : 3'h2;
		end else if (submode >= SM_DC_565 && submode <= SM_DC_4444) begin
			lg_bpp = 3'h4;
		end
		bpp = 6'h01 << lg_bpp;
		pix_per_latch = (lg_bus > lg_bpp) ? 5'(5'h01 << (lg_bus - lg_bpp)) : 5'h01;
	end

	// Capture a bus word per latch edge, then shift out low pixels first
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			shift_reg <= 64'h0000_0000_0000_0000;
			remain_reg <= 5'h00;
			blank_n_reg <= 1'b0;
		end else if (latch_evt) begin
			if (vga_active) begin
				shift_reg <= {56'h00_0000_0000_0000, pin_s3_reg.vga};
				remain_reg <= 5'h01;
				blank_n_reg <= pin_s3_reg.vga_blank_n;
			end else begin
				if (color_mode == PMF_PSEUDO && submode == SM_PS_SWAP) begin
					shift_reg <= swap_nibbles(pin_s3_reg.pix & bus_mask(bus_code));
				end else begin
					shift_reg <= pin_s3_reg.pix & bus_mask(bus_code);
				end
				remain_reg <= pix_per_latch;
				blank_n_reg <= pin_s3_reg.pix_blank_n;
			end
		end else if (pix_present) begin
			shift_reg <= shift_reg >> bpp;
			remain_reg <= remain_reg - 5'h01;
		end
	end

	assign cur = shift_reg[31:0];

	// Pixel field decode
	always_comb begin
		dec = '0;
		ovl_addr = 8'h00;
		if (pseudo_like) begin
			if (!vga_active && submode != SM_PS_BYTE) begin
				ovl_addr = {page_reg[7:4], cur[3:0]};
			end else begin
				ovl_addr = cur[7:0];
			end
		end else begin
			case (submode)
				SM_DC_ORGB: begin
					dec = {1'b1, cur};
				end
				SM_DC_BGRO: begin
					dec = {1'b1, cur[7:0], cur[15:8], cur[23:16], cur[31:24]};
				end
				SM_DC_565: begin
					dec.rgb = {cur[15:11], 3'h0, cur[10:5], 2'h0, cur[4:0], 3'h0};
				end
				SM_DC_1555: begin
					dec.has_ovl = 1'b1;
					dec.ovl = {page_reg[7:1], cur[15]};
					dec.rgb = {cur[14:10], 3'h0, cur[9:5], 3'h0, cur[4:0], 3'h0};
				end
				SM_DC_664: begin
					dec.rgb = {cur[15:10], 2'h0, cur[9:4], 2'h0, cur[3:0], 4'h0};
				end
				SM_DC_4444: begin
					dec.has_ovl = 1'b1;
					dec.ovl = {page_reg[7:4], cur[15:12]};
					dec.rgb = {cur[11:8], 4'h0, cur[7:4], 4'h0, cur[3:0], 4'h0};
				end
				default: begin
					dec = {1'b1, cur};
				end
			endcase
			if (color_mode == PMF_TRUE) begin
				dec.has_ovl = 1'b0;
			end
			ovl_addr = dec.ovl;
		end
		ovl_addr = ovl_addr & read_mask_reg;
		if (!pseudo_like && color_mode == PMF_TRUE) begin
			rd_addr_r = dec.rgb.red;
			rd_addr_g = dec.rgb.green;
			rd_addr_b = dec.rgb.blue;
		end else begin
			rd_addr_r = ovl_addr;
			rd_addr_g = ovl_addr;
			rd_addr_b = ovl_addr;
		end
	end

	// Palette tables: written from the register port, read by the pixel path
	always_ff @(posedge clk_sys) begin
		if (reg_req.wr && reg_req.addr == OFS_PAL_DATA) begin
			pal_red[pal_index_reg] <= reg_req.wdata[23:16];
			pal_green[pal_index_reg] <= reg_req.wdata[15:8];
			pal_blue[pal_index_reg] <= reg_req.wdata[7:0];
		end
		pal_q_reg <= {pal_red[rd_addr_r], pal_green[rd_addr_g], pal_blue[rd_addr_b]};
	end

	// Lookup stage; direct data waits here as long as the palette read
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			dec_b_reg <= '0;
			pseudo_b_reg <= 1'b1;
			true_b_reg <= 1'b0;
			use_pal_b_reg <= 1'b1;
			valid_b_reg <= 1'b0;
			blank_b_reg <= 1'b0;
			dac8_b_reg <= 1'b1;
			pal_addr_out <= 8'h00;
		end else begin
			dec_b_reg <= dec;
			pseudo_b_reg <= pseudo_like;
			true_b_reg <= color_mode == PMF_TRUE;
			use_pal_b_reg <= use_palette;
			valid_b_reg <= pix_present;
			blank_b_reg <= blank_n_reg;
			dac8_b_reg <= misc_ctrl_reg[DAC_8BIT_BIT];
			pal_addr_out <= ovl_addr;
		end
	end

	// Output select to the DACs
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			dac_data <= '0;
			dac_blank_n <= 1'b0;
			pix_valid <= 1'b0;
		end else begin
			pix_valid <= valid_b_reg;
			dac_blank_n <= blank_b_reg;
			if (!valid_b_reg) begin
				dac_data <= '0;
			end else if (pseudo_b_reg || (use_pal_b_reg && !true_b_reg && dec_b_reg.has_ovl)) begin
				dac_data.red <= dac_width(pal_q_reg.red, dac8_b_reg);
				dac_data.green <= dac_width(pal_q_reg.green, dac8_b_reg);
				dac_data.blue <= dac_width(pal_q_reg.blue, dac8_b_reg);
			end else if (true_b_reg && use_pal_b_reg) begin
				dac_data <= pal_q_reg;
			end else begin
				dac_data <= dec_b_reg.rgb;
			end
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	sequence s_direct_in;
		pix_present && !pseudo_like && color_mode == PMF_DIRECT && !use_palette;
	endsequence

	sequence s_swap_latch;
		latch_evt && !vga_active && color_mode == PMF_PSEUDO && submode == SM_PS_SWAP;
	endsequence

	a_reset_vga_mode:
	assert property ($rose(nrst) |-> vga_active && !vga_latch_src && pseudo_like)
		else $error("VGA mode not active after reset");
	a_reset_path_sel:
	assert property ($rose(nrst) |-> use_palette && key_ctrl_reg == 8'h00)
		else $error("path selection not at default after reset");
	a_vga_capture:
	assert property (vga_active && !vga_latch_src && vclk_rise |=>
		remain_reg == 5'h01 && shift_reg[7:0] == $past(pin_s3_reg.vga))
		else $error("VGA data not captured on VGA clock");
	a_nibble_page:
	assert property (pix_present && !vga_active && color_mode == PMF_PSEUDO &&
		submode == SM_PS_NIBBLE |-> ovl_addr == ({page_reg[7:4], cur[3:0]} & read_mask_reg))
		else $error("submode 1 address wrong");
	a_swap_order:
	assert property (s_swap_latch |=> shift_reg[3:0] == $past(pin_s3_reg.pix[7:4]))
		else $error("upper nibble not first");
	a_byte_address:
	assert property (pix_present && pseudo_like && (vga_active || submode == SM_PS_BYTE)
		|-> ovl_addr == (cur[7:0] & read_mask_reg))
		else $error("byte pixel address wrong");
	a_direct_latency:
	assert property (s_direct_in |-> ##2 pix_valid && dac_data == $past(dec.rgb, 2))
		else $error("direct colour latency wrong");
	a_left_justify:
	assert property (!pseudo_like && submode == SM_DC_565 |->
		dec.rgb.red[2:0] == 3'h0 && dec.rgb.green[1:0] == 2'h0 && dec.rgb.blue[2:0] == 3'h0)
		else $error("narrow field not left-justified");
	a_true_no_overlay:
	assert property (!pseudo_like && color_mode == PMF_TRUE |-> !dec.has_ovl &&
		rd_addr_g == dec.rgb.green)
		else $error("true colour uses overlay");
	a_overlay_page:
	assert property (!pseudo_like && submode == SM_DC_4444 && color_mode == PMF_DIRECT |->
		ovl_addr[7:4] == (page_reg[7:4] & read_mask_reg[7:4]))
		else $error("overlay page fill wrong");
	a_upper_lines:
	assert property (latch_evt && !vga_active && bus_code == 2'h0 |=>
		shift_reg[63:8] == 56'h00_0000_0000_0000)
		else $error("unused bus lines leaked");
endmodule

/* verification/pmf_pixel_source.sv */
// Far-side model: graphics controller driving the pixel bus and the VGA port.
// Assumes a 160 ns link period; link clocks stand low between words.
`timescale 1ns/10ps
module pmf_pixel_source (
	output logic latch_clock_in,
	output logic [63:0] pixel_bus_in,
	output logic pixel_blank_n_in,
	output logic vga_clock_input,
	output logic [7:0] vga_pixel_inputs,
	output logic vga_blank_n_in
);
	initial begin
		latch_clock_in = 1'b0;
		vga_clock_input = 1'b0;
		pixel_bus_in = 64'h0000_0000_0000_0000;
		pixel_blank_n_in = 1'b0;
		vga_pixel_inputs = 8'h00;
		vga_blank_n_in = 1'b0;
	end

	// One word, set up before the rising edge, then released as inverse
	task automatic send(input logic [63:0] word, input logic to_vga);
		if (to_vga) begin
			vga_pixel_inputs = word[7:0];
			vga_blank_n_in = 1'b1;
			#40 vga_clock_input = 1'b1;
			#80 vga_clock_input = 1'b0;
			#40 vga_pixel_inputs = ~word[7:0];
			vga_blank_n_in = 1'b0;
		end else begin
			pixel_bus_in = word;
			pixel_blank_n_in = 1'b1;
			#40 latch_clock_in = 1'b1;
			#80 latch_clock_in = 1'b0;
			#40 pixel_bus_in = ~word;
			pixel_blank_n_in = 1'b0;
		end
	endtask
endmodule

/* verification/pmf_formatter_bench.sv */
// Self-checking bench of the pixel mode formatter.
// Assumes the pixel source model and a 50 MHz system clock.
`timescale 1ns/10ps
module pmf_formatter_bench;
	import pmf_pkg::*;
	logic clk_sys = 1'b0;
	logic nrst;
	pmf_reg_req_t reg_req;
	logic [31:0] reg_rdata;
	wire logic lclk, pblank_n, vclk, vblank_n;
	wire logic [63:0] pbus;
	wire logic [7:0] vdata;
	pmf_rgb_t dac_data;
	logic dac_blank_n;
	logic [7:0] pal_addr;
	logic pix_valid;
	int error_cnt = 0;
	int comparisons = 0;
	pmf_rgb_t got_q[$];
	pmf_rgb_t exp_q[$];
	logic blank_q[$];
	logic [7:0] addr_q[$];
	logic [7:0] exp_addr_q[$];
	logic [7:0] addr_prev = 8'h00;

	always #10 clk_sys = ~clk_sys;

	pmf_formatter DUT (.clk_sys(clk_sys), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.latch_clock_in(lclk), .pixel_bus_in(pbus), .pixel_blank_n_in(pblank_n),
		.vga_clock_input(vclk), .vga_pixel_inputs(vdata), .vga_blank_n_in(vblank_n),
		.dac_data(dac_data), .dac_blank_n(dac_blank_n), .pal_addr_out(pal_addr),
		.pix_valid(pix_valid));

	pmf_pixel_source src (.latch_clock_in(lclk), .pixel_bus_in(pbus), .pixel_blank_n_in(pblank_n),
		.vga_clock_input(vclk), .vga_pixel_inputs(vdata), .vga_blank_n_in(vblank_n));

	// Collects every shown pixel, its blank and the palette address one cycle ahead
	always @(posedge clk_sys) begin
		if (pix_valid === 1'b1) begin
			got_q.push_back(dac_data);
			blank_q.push_back(dac_blank_n);
			addr_q.push_back(addr_prev);
		end
		addr_prev = pal_addr;
	end

	function automatic pmf_rgb_t pv(input logic [7:0] i);
		return {i, ~i, i ^ 8'h5A};
	endfunction

	function automatic pmf_rgb_t six(input pmf_rgb_t v);
		return {v.red[5:0], 2'b00, v.green[5:0], 2'b00, v.blue[5:0], 2'b00};
	endfunction

	task automatic end_sim;
		$display("comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t register read %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_pix(input pmf_rgb_t got, input pmf_rgb_t exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t pixel %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask

	task automatic chk_addr(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t palette address %h expected %h", $time, got, exp);
		end
	endtask

	task automatic reg_wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		reg_req.wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [5:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys);
		reg_req.rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// Sends one word and compares the pixels shown against exp_q
	task automatic xfer(input logic [63:0] w, input logic to_vga);
		int k;
		got_q.delete();
		blank_q.delete();
		addr_q.delete();
		src.send(w, to_vga);
		for (k = 0; k < 40 && got_q.size() < exp_q.size(); k++) @(posedge clk_sys);
		repeat (12) @(posedge clk_sys);
		comparisons++;
		if (got_q.size() != exp_q.size()) begin
			error_cnt++;
			$display("[ERR] %0t got %0d pixels expected %0d", $time, got_q.size(), exp_q.size());
		end else begin
			for (k = 0; k < exp_q.size(); k++) begin
				chk_pix(got_q[k], exp_q[k]);
				chk_bit(blank_q[k], 1'b1);
			end
			for (k = 0; k < exp_addr_q.size(); k++) begin
				chk_addr(addr_q[k], exp_addr_q[k]);
			end
		end
		exp_q.delete();
		exp_addr_q.delete();
	endtask

	task automatic t_reset;
		logic [31:0] d;
		logic [7:0] tab [8];
		tab = '{RST_MUX_CTRL, RST_MODE_CTRL, RST_PAGE, RST_READ_MASK, RST_MISC_CTRL,
			RST_KEY_CTRL, RST_CLOCK_SEL, RST_PAL_INDEX};
		chk_bit(pix_valid, 1'b0);
		chk_bit(dac_blank_n, 1'b0);
		for (int i = 0; i < 8; i++) begin
			reg_rd(6'(i * 4), d);
			chk_reg(d, {24'h00_0000, tab[i]});
		end
		reg_wr(6'h3C, 32'h0000_00FF);
		reg_rd(6'h3C, d);
		chk_reg(d, 32'h0000_0000);
		reg_wr(OFS_PAGE, 32'h0000_0070);
		reg_rd(OFS_PAGE, d);
		chk_reg(d, 32'h0000_0070);
	endtask

	task automatic t_vga;
		logic [31:0] d;
		reg_wr(OFS_PAL_INDEX, 32'h0000_0000);
		for (int i = 0; i < 256; i++) reg_wr(OFS_PAL_DATA, {8'h00, pv(8'(i))});
		reg_wr(OFS_CLOCK_SEL, {28'h000_0000, CLOCK_SOURCE_VGA});
		reg_rd(OFS_STATUS, d);
		chk_reg(d & 32'h0000_003C, 32'h0000_001C);
		exp_q = '{pv(8'h3C)};
		exp_addr_q = '{8'h3C};
		xfer(64'h0000_0000_0000_003C, 1'b1);
	endtask

	task automatic t_pseudo;
		reg_wr(OFS_MUX_CTRL, 32'h0000_0013);
		exp_q = '{pv(8'h4D), pv(8'hB2)};
		xfer(64'hFFFF_FFFF_FFFF_B24D, 1'b0);
		reg_wr(OFS_MUX_CTRL, 32'h0000_0001);
		exp_q = '{pv(8'h7E), pv(8'h79)};
		exp_addr_q = '{8'h7E, 8'h79};
		xfer(64'hFFFF_FFFF_FFFF_FF9E, 1'b0);
		reg_wr(OFS_MUX_CTRL, 32'h0000_0002);
		exp_q = '{pv(8'h79), pv(8'h7E)};
		xfer(64'hFFFF_FFFF_FFFF_FF9E, 1'b0);
		reg_wr(OFS_MUX_CTRL, 32'h0000_0033);
		exp_q = '{pv(8'h01), pv(8'h02), pv(8'h03), pv(8'h04), pv(8'h05), pv(8'h06),
			pv(8'h07), pv(8'h08)};
		xfer(64'h0807_0605_0403_0201, 1'b0);
		reg_wr(OFS_MUX_CTRL, 32'h0000_0003);
		reg_wr(OFS_READ_MASK, 32'h0000_000F);
		exp_q = '{pv(8'h02)};
		exp_addr_q = '{8'h02};
		xfer(64'h0000_0000_0000_00B2, 1'b0);
		reg_wr(OFS_READ_MASK, 32'h0000_00FF);
		reg_wr(OFS_MISC_CTRL, 32'h0000_0000);
		exp_q = '{six(pv(8'hB2))};
		xfer(64'h0000_0000_0000_00B2, 1'b0);
	endtask

	task automatic t_direct;
		reg_wr(OFS_MODE_CTRL, 32'h0000_0001);
		reg_wr(OFS_MISC_CTRL, 32'h0000_0028);
		reg_wr(OFS_MUX_CTRL, 32'h0000_0015);
		exp_q = '{24'hA8_A858};
		xfer(64'hFFFF_FFFF_FFFF_AD4B, 1'b0);
		reg_wr(OFS_MUX_CTRL, 32'h0000_0017);
		exp_q = '{24'hB4_4C90};
		xfer(64'h0000_0000_0000_B539, 1'b0);
		reg_wr(OFS_MUX_CTRL, 32'h0000_0016);
		exp_q = '{24'h88_50F8};
		xfer(64'h0000_0000_0000_C55F, 1'b0);
		reg_wr(OFS_MUX_CTRL, 32'h0000_0018);
		exp_q = '{24'hA0_30C0};
		xfer(64'h0000_0000_0000_5A3C, 1'b0);
		reg_wr(OFS_MUX_CTRL, 32'h0000_0033);
		exp_q = '{24'h22_3344, 24'h66_7788};
		xfer(64'h5566_7788_1122_3344, 1'b0);
		reg_wr(OFS_MUX_CTRL, 32'h0000_0024);
		exp_q = '{24'h33_2211};
		xfer(64'h0000_0000_1122_3344, 1'b0);
	endtask

	task automatic t_overlay;
		reg_wr(OFS_MISC_CTRL, 32'h0000_0008);
		reg_wr(OFS_MUX_CTRL, 32'h0000_0016);
		exp_q = '{pv(8'h71)};
		exp_addr_q = '{8'h71};
		xfer(64'h0000_0000_0000_C55F, 1'b0);
		reg_wr(OFS_MUX_CTRL, 32'h0000_0018);
		exp_q = '{pv(8'h75)};
		xfer(64'h0000_0000_0000_5A3C, 1'b0);
		reg_wr(OFS_MISC_CTRL, 32'h0000_0028);
		reg_wr(OFS_KEY_CTRL, 32'h0000_0011);
		exp_q = '{pv(8'h75)};
		xfer(64'h0000_0000_0000_5A3C, 1'b0);
		reg_wr(OFS_KEY_CTRL, 32'h0000_0000);
		reg_wr(OFS_MISC_CTRL, 32'h0000_0000);
		exp_q = '{six(pv(8'h75))};
		xfer(64'h0000_0000_0000_5A3C, 1'b0);
	endtask

	task automatic t_true;
		pmf_rgb_t e;
		e = {pv(8'h10).red, pv(8'h20).green, pv(8'h30).blue};
		reg_wr(OFS_MODE_CTRL, 32'h0000_0002);
		reg_wr(OFS_MUX_CTRL, 32'h0000_0023);
		exp_q = '{e};
		xfer(64'h0000_0000_0010_2030, 1'b0);
		reg_wr(OFS_MISC_CTRL, 32'h0000_0008);
		reg_wr(OFS_MODE_CTRL, 32'h0000_0000);
		reg_wr(OFS_MUX_CTRL, 32'h0000_00C0);
		xfer(64'h0000_0000_0000_00C3, 1'b1);
		reg_wr(OFS_MUX_CTRL, 32'h0000_0080);
		exp_q = '{pv(8'hC3)};
		xfer(64'h0000_0000_0000_00C3, 1'b1);
	endtask

	initial begin
		nrst = 1'b0;
		reg_req = '0;
		repeat (20) @(posedge clk_sys);
		nrst <= 1'b1;
		t_reset();
		t_vga();
		t_pseudo();
		t_direct();
		t_overlay();
		t_true();
		end_sim();
	end
endmodule
